// [rtl/mop_defines.svh]
// constants for the motor overload protection block
//
// Contract
// - setting accepts zero to 500 amperes
// - zero setting disables heat accumulator only
// - power or reset input clears heat
// - 85 percent raises alarm and display
// - 100 percent trips with motor overload fault
// - alarm alone never causes a trip
// - alarm terminal codes 8 high, 108 low
// - outside relay input trips with relay fault
// - relay input from terminal coded 7
// - low speed trips earlier, less cooling
`ifndef MOP_DEFINES_SVH
`define MOP_DEFINES_SVH

// register byte offsets
`define MOP_ADDR_SETTING 8'h00
`define MOP_ADDR_OUTFUNC 8'h04
`define MOP_ADDR_INFUNC 8'h08
`define MOP_ADDR_STATUS 8'h0C
`define MOP_ADDR_INTSTAT 8'h10
`define MOP_ADDR_INTMASK 8'h14
`define MOP_ADDR_HEAT 8'h18

// reset values and limits
`define MOP_SETTING_MAX 10'h1F4
`define MOP_SETTING_RST 10'h00A
`define MOP_OUTFUNC_RST 24'h000000
`define MOP_INFUNC_RST 32'h00000000
`define MOP_INTMASK_RST 4'h0

// terminal function codes
`define MOP_CODE_ALARM_POS 8'h08
`define MOP_CODE_ALARM_NEG 8'h6C
`define MOP_CODE_RELAY 8'h07

// heat levels and rates
`define MOP_HEAT_TRIP 24'h100000
`define MOP_HEAT_PRE 24'h0D999A
`define MOP_HEAT_DECAY 24'h000040
`define MOP_GAIN_SHIFT 4
`define MOP_LOW_SPEED 13'h012C

// interrupt status bit positions
`define MOP_INT_PRE 0
`define MOP_INT_MOTOR 1
`define MOP_INT_STAGE 2
`define MOP_INT_RELAY 3

// timing: heat step period
`define MOP_TICK_US 1000
`define MOP_CLK_NS 50
`define MOP_TICK_CYCLES ((`MOP_TICK_US * 1000) / `MOP_CLK_NS)

`endif

// [rtl/mop_pkg.sv]
// types shared by the motor overload protection files
package mop_pkg;

  // latched fault code
  typedef enum logic [1:0] {
    MOP_NO_FAULT = 2'h0,
    MOP_MOTOR_OVERLOAD_FAULT = 2'h1,
    MOP_POWER_STAGE_OVERLOAD_FAULT = 2'h2,
    MOP_OUTSIDE_RELAY_FAULT = 2'h3
  } mop_fault_t;

  // synchroniser state
  typedef struct packed {
    logic [4:0] ff1;
    logic [4:0] ff2;
    logic [4:0] ff3;
    logic [4:0] level;
  } mop_sync_t;

  // tick generator state
  typedef struct packed {
    logic [15:0] count;
    logic tick;
  } mop_tick_t;

endpackage

// [rtl/mop_pin_sync.sv]
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ns
`default_nettype none
module mop_pin_sync (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // raw pins
  input wire logic [4:0] pinIn,
  // settled levels
  output logic [4:0] pinLevel
);

  mop_pkg::mop_sync_t s_q; // all state
  mop_pkg::mop_sync_t s_d; // next state

  // shift chain; level follows once stages two and three agree
  always_comb begin
    s_d = s_q;
    s_d.ff1 = pinIn;
    s_d.ff2 = s_q.ff1;
    s_d.ff3 = s_q.ff2;
    for (int i = 0; i < 5; i++) begin
      if (s_q.ff2[i] == s_q.ff3[i]) begin
        s_d.level[i] = s_q.ff3[i];
      end
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pinLevel = s_q.level;

endmodule // mop_pin_sync
`default_nettype wire

// [rtl/mop_tick.sv]
// periodic one-cycle tick for heat stepping
`timescale 1ns/1ns
`default_nettype none
module mop_tick #(
  parameter int CYCLES = 20000
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // one pulse every CYCLES clocks
  output logic tick
);

  localparam logic [15:0] LAST = 16'(CYCLES - 1); // final count

  mop_pkg::mop_tick_t s_q; // all state
  mop_pkg::mop_tick_t s_d; // next state

  // free-running divider
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    if (s_q.count >= LAST) begin
      s_d.count = 16'h0000;
      s_d.tick = 1'b1;
    end else begin
      s_d.count = s_q.count + 16'h0001;
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tick = s_q.tick;

endmodule // mop_tick
`default_nettype wire

// [rtl/mop_protection.sv]
// motor overload protection: heat accumulator, trips, terminals, apb registers
`timescale 1ns/1ns
`default_nettype none
`include "mop_defines.svh"
module mop_protection #(
  parameter int TICK_CYCLES = `MOP_TICK_CYCLES
) (
  // clock and reset
  input wire logic clock,
  input wire logic rst,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // drive measurements, same clock
  input wire logic [9:0] motorCurrent,
  input wire logic [12:0] motorSpeed,
  input wire logic powerStageOverload,
  // pins from outside
  input wire logic [3:0] inTermPin,
  input wire logic resetPin,
  // protection outputs
  output logic motorHeatAlarmOut,
  output logic motorHeatPrealarmDisplay,
  output logic outputShutoff,
  output logic [1:0] faultCode,
  output logic [2:0] outTerm,
  output logic irq
);

  // whole block state
  typedef struct packed {
    logic [9:0] setting;
    logic [2:0][7:0] outCode;
    logic [3:0][7:0] inCode;
    logic [23:0] heat;
    logic alarm;
    logic trip;
    mop_pkg::mop_fault_t fault;
    logic [3:0] intStat;
    logic [3:0] intMask;
    logic [2:0] outTerm;
    logic irq;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mop_top_t;

  mop_top_t s_q; // registered state
  mop_top_t s_d; // next state

  logic [4:0] pinLevel; // settled pin levels
  logic tick; // heat step strobe
  logic resetIn; // settled reset input
  logic externalRelayTripInput; // relay input from coded terminals
  logic lowSpeed; // reduced cooling region
  logic [9:0] effSetting; // setting after cooling derate

  // pin synchroniser for input terminals and reset pin
  mop_pin_sync mop_pin_sync_i (
    .clock(clock),
    .rst(rst),
    .pinIn({resetPin, inTermPin}),
    .pinLevel(pinLevel)
  );

  // heat step timebase
  mop_tick #(
    .CYCLES(TICK_CYCLES)
  ) mop_tick_i (
    .clock(clock),
    .rst(rst),
    .tick(tick)
  );

  // terminal level for one output terminal
  function automatic logic outLevel(input logic [7:0] code, input logic alarm);
    if (code == `MOP_CODE_ALARM_POS) begin
      outLevel = alarm;
    end else if (code == `MOP_CODE_ALARM_NEG) begin
      outLevel = ~alarm;
    end else begin
      outLevel = 1'b0;
    end
  endfunction

  // true for a mapped register word
  function automatic logic regHit(input logic [7:0] addr);
    case (addr)
      `MOP_ADDR_SETTING, `MOP_ADDR_OUTFUNC, `MOP_ADDR_INFUNC, `MOP_ADDR_STATUS,
      `MOP_ADDR_INTSTAT, `MOP_ADDR_INTMASK, `MOP_ADDR_HEAT: regHit = 1'b1;
      default: regHit = 1'b0;
    endcase
  endfunction

  // one heat step: rise by excess current, else decay, clamp both ends
  function automatic logic [23:0] heatStep(input logic [23:0] heat,
                                           input logic [9:0] current,
                                           input logic [9:0] limit);
    logic [24:0] sum;
    logic [23:0] rise;
    sum = 25'h0000000;
    rise = 24'h000000;
    if (current > limit) begin
      rise = 24'({current - limit, 4'h0});
      sum = {1'b0, heat} + {1'b0, rise};
      if (sum >= {1'b0, `MOP_HEAT_TRIP}) begin
        heatStep = `MOP_HEAT_TRIP;
      end else begin
        heatStep = sum[23:0];
      end
    end else if (heat > `MOP_HEAT_DECAY) begin
      heatStep = heat - `MOP_HEAT_DECAY;
    end else begin
      heatStep = 24'h000000;
    end
  endfunction

  // settled reset pin
  assign resetIn = pinLevel[4];

  // slow running derates the setting by a quarter
  assign lowSpeed = (motorSpeed < `MOP_LOW_SPEED);
  assign effSetting = lowSpeed ? (s_q.setting - {2'b00, s_q.setting[9:2]}) : s_q.setting;

  // relay input is any terminal coded as relay input that is on
  always_comb begin
    externalRelayTripInput = 1'b0;
    for (int i = 0; i < 4; i++) begin
      if (s_q.inCode[i] == `MOP_CODE_RELAY && pinLevel[i]) begin
        externalRelayTripInput = 1'b1;
      end
    end
  end

  // next-state logic for bus, heat, trips and interrupts
  always_comb begin
    logic access;
    logic commit;
    logic [3:0] events;
    logic [3:0] clearBits;
    access = 1'b0;
    commit = 1'b0;
    events = 4'h0;
    clearBits = 4'h0;
    s_d = s_q;
    access = psel & penable;
    commit = access & s_q.pready;
    // apb answer one cycle into the access phase
    s_d.pready = access & ~s_q.pready;
    if (access && !s_q.pready) begin
      s_d.pslverr = ~regHit(paddr);
      case (paddr)
        `MOP_ADDR_SETTING: s_d.prdata = {22'h000000, s_q.setting};
        `MOP_ADDR_OUTFUNC: s_d.prdata = {8'h00, s_q.outCode};
        `MOP_ADDR_INFUNC: s_d.prdata = s_q.inCode;
        `MOP_ADDR_STATUS: s_d.prdata = {26'h0000000, lowSpeed, externalRelayTripInput,
                                        s_q.fault, s_q.trip, s_q.alarm};
        `MOP_ADDR_INTSTAT: s_d.prdata = {28'h0000000, s_q.intStat};
        `MOP_ADDR_INTMASK: s_d.prdata = {28'h0000000, s_q.intMask};
        `MOP_ADDR_HEAT: s_d.prdata = {8'h00, s_q.heat};
        default: s_d.prdata = 32'h00000000;
      endcase
    end else if (!access) begin
      // idle bus shows zero
      s_d.prdata = 32'h00000000;
      s_d.pslverr = 1'b0;
    end
    // writes take effect on the edge that samples pready
    if (commit && pwrite && !s_q.pslverr) begin
      case (paddr)
        `MOP_ADDR_SETTING: begin
          // values above the range clamp to the top
          if (pwdata[31:0] > {22'h000000, `MOP_SETTING_MAX}) begin
            s_d.setting = `MOP_SETTING_MAX;
          end else begin
            s_d.setting = pwdata[9:0];
          end
        end
        `MOP_ADDR_OUTFUNC: s_d.outCode = pwdata[23:0];
        `MOP_ADDR_INFUNC: s_d.inCode = pwdata;
        `MOP_ADDR_INTSTAT: clearBits = pwdata[3:0];
        `MOP_ADDR_INTMASK: s_d.intMask = pwdata[3:0];
        default: s_d.intMask = s_q.intMask;
      endcase
    end
    // heat accumulator and trip logic
    if (resetIn) begin
      // reset input clears heat and releases a latched trip
      s_d.heat = 24'h000000;
      s_d.trip = 1'b0;
      s_d.fault = mop_pkg::MOP_NO_FAULT;
      s_d.alarm = 1'b0;
    end else begin
      if (s_q.setting == 10'h000) begin
        // accumulator off, power-stage check still active
        s_d.heat = 24'h000000;
      end else if (tick) begin
        s_d.heat = heatStep(s_q.heat, motorCurrent, effSetting);
      end
      // alarm at 85 percent; it never trips by itself
      s_d.alarm = (s_q.setting != 10'h000) && (s_q.heat >= `MOP_HEAT_PRE);
      if (!s_q.alarm && s_d.alarm) begin
        events[`MOP_INT_PRE] = 1'b1;
      end
      if (!s_q.trip) begin
        // first cause wins, relay first
        if (externalRelayTripInput) begin
          s_d.trip = 1'b1;
          s_d.fault = mop_pkg::MOP_OUTSIDE_RELAY_FAULT;
          events[`MOP_INT_RELAY] = 1'b1;
        end else if (powerStageOverload) begin
          s_d.trip = 1'b1;
          s_d.fault = mop_pkg::MOP_POWER_STAGE_OVERLOAD_FAULT;
          events[`MOP_INT_STAGE] = 1'b1;
        end else if (s_q.setting != 10'h000 && s_q.heat >= `MOP_HEAT_TRIP) begin
          s_d.trip = 1'b1;
          s_d.fault = mop_pkg::MOP_MOTOR_OVERLOAD_FAULT;
          events[`MOP_INT_MOTOR] = 1'b1;
        end
      end
    end
    // sticky status, a new event wins over a clear in the same cycle
    s_d.intStat = (s_q.intStat & ~clearBits) | events;
    s_d.irq = |(s_d.intStat & s_d.intMask);
    // terminal outputs follow their function codes
    for (int i = 0; i < 3; i++) begin
      s_d.outTerm[i] = outLevel(s_q.outCode[i], s_q.alarm);
    end
  end

  // state register
  always_ff @(posedge clock) begin
    if (rst) begin
      s_q <= '0;
      s_q.setting <= `MOP_SETTING_RST;
      s_q.outCode <= `MOP_OUTFUNC_RST;
      s_q.inCode <= `MOP_INFUNC_RST;
      s_q.intMask <= `MOP_INTMASK_RST;
      s_q.fault <= mop_pkg::MOP_NO_FAULT;
    end else begin
      s_q <= s_d;
    end
  end

  // outputs straight from state flops
  assign prdata = s_q.prdata;
  assign pready = s_q.pready;
  assign pslverr = s_q.pslverr;
  assign motorHeatAlarmOut = s_q.alarm;
  assign motorHeatPrealarmDisplay = s_q.alarm;
  assign outputShutoff = s_q.trip;
  assign faultCode = s_q.fault;
  assign outTerm = s_q.outTerm;
  assign irq = s_q.irq;

  // setting never leaves its range
  chk_setting_range: assert property (
    @(posedge clock) disable iff (rst)
    s_q.setting <= `MOP_SETTING_MAX)
    else $error("overload setting above range");

  // zero setting empties the accumulator next cycle
  chk_zero_disables_heat: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.setting == 10'h000) |=> (s_q.heat == 24'h000000) && !s_q.alarm)
    else $error("heat not held at zero with zero setting");

  // reset input clears heat and trip
  chk_reset_clears: assert property (
    @(posedge clock) disable iff (rst)
    resetIn |=> (s_q.heat == 24'h000000) && !s_q.trip
                && (s_q.fault == mop_pkg::MOP_NO_FAULT))
    else $error("reset input did not clear heat or trip");

  // prealarm follows the 85 percent level one cycle later
  chk_prealarm_level: assert property (
    @(posedge clock) disable iff (rst)
    (!resetIn && s_q.setting != 10'h000 && s_q.heat >= `MOP_HEAT_PRE)
    |=> motorHeatAlarmOut && motorHeatPrealarmDisplay)
    else $error("prealarm missing at 85 percent");

  // full level trips with motor fault when nothing else is pending
  chk_trip_level: assert property (
    @(posedge clock) disable iff (rst)
    (!resetIn && !s_q.trip && s_q.setting != 10'h000 && s_q.heat >= `MOP_HEAT_TRIP
     && !externalRelayTripInput && !powerStageOverload)
    |=> outputShutoff && faultCode == mop_pkg::MOP_MOTOR_OVERLOAD_FAULT)
    else $error("no motor overload trip at full level");

  // alarm below trip level keeps the drive running
  chk_alarm_no_trip: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.alarm && !s_q.trip && s_q.heat < `MOP_HEAT_TRIP
     && !externalRelayTripInput && !powerStageOverload)
    |=> !outputShutoff)
    else $error("alarm alone caused a trip");

  // positive and negative alarm terminal codes
  chk_alarm_terminal: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.outCode[0] == `MOP_CODE_ALARM_POS || s_q.outCode[0] == `MOP_CODE_ALARM_NEG)
    |=> outTerm[0] == ($past(s_q.alarm) ^ ($past(s_q.outCode[0]) == `MOP_CODE_ALARM_NEG)))
    else $error("alarm terminal level wrong");

  // relay input trips with its own fault code
  chk_relay_trip: assert property (
    @(posedge clock) disable iff (rst)
    (!resetIn && !s_q.trip && externalRelayTripInput)
    |=> outputShutoff && faultCode == mop_pkg::MOP_OUTSIDE_RELAY_FAULT)
    else $error("outside relay did not trip");

  // accumulator never passes the trip level
  chk_heat_saturates: assert property (
    @(posedge clock) disable iff (rst)
    s_q.heat <= `MOP_HEAT_TRIP)
    else $error("heat above trip level");

  // heat does not move between ticks
  chk_heat_steps: assert property (
    @(posedge clock) disable iff (rst)
    (!tick && !resetIn && s_q.setting != 10'h000) |=> $stable(s_q.heat))
    else $error("heat changed without a tick");

  // a trip and its code hold until reset input
  chk_trip_latch: assert property (
    @(posedge clock) disable iff (rst)
    (s_q.trip && !resetIn) |=> outputShutoff && $stable(faultCode))
    else $error("trip released without reset");

  // power-stage overload trips even with the accumulator off
  chk_stage_trip: assert property (
    @(posedge clock) disable iff (rst)
    (!resetIn && !s_q.trip && !externalRelayTripInput && powerStageOverload)
    |=> outputShutoff && faultCode == mop_pkg::MOP_POWER_STAGE_OVERLOAD_FAULT)
    else $error("power stage overload did not trip");

  // prealarm rise is recorded even against a clear in the same cycle
  chk_prealarm_sticky: assert property (
    @(posedge clock) disable iff (rst)
    $rose(motorHeatAlarmOut) |-> s_q.intStat[`MOP_INT_PRE])
    else $error("prealarm rise not recorded in status");

endmodule // mop_protection
`default_nettype wire

// [bench/mop_relay_model.sv]
// thermal relay and reset switch wired to the drive's input terminals
`timescale 1ns/1ns
`default_nettype none
module mop_relay_model #(
  parameter int TERM = 1
) (
  // clock that paces contact changes
  input wire logic clock,
  // commands from the bench
  input wire logic relayHot,
  input wire logic resetReq,
  // terminal pins into the drive
  output var logic [3:0] inTermPin = 4'h0,
  output var logic resetPin = 1'b0
);
  // open contacts read low through the terminal pull-downs
  always @(posedge clock) begin
    inTermPin <= 4'(relayHot) << TERM; // contact closes while the motor is hot
    resetPin <= resetReq; // reset switch, held as long as asked
  end
endmodule // mop_relay_model
`default_nettype wire

// [bench/mop_protection_tb.sv]
// self-checking bench for the motor overload protection block
`timescale 1ns/1ns
`default_nettype none
`include "mop_defines.svh"
module mop_protection_tb;
  // clock, reset and apb master signals
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  // drive measurements and pins
  logic [9:0] motorCurrent = 10'h000;
  logic [12:0] motorSpeed = 13'h03E8;
  logic powerStageOverload = 1'b0, relayHot = 1'b0, resetReq = 1'b0;
  logic [3:0] inTermPin;
  logic resetPin, motorHeatAlarmOut, motorHeatPrealarmDisplay, outputShutoff, irq;
  logic [1:0] faultCode;
  logic [2:0] outTerm;
  int n_fail = 0, checked = 0;

  // 20 MHz clock
  always #25 clock = ~clock;

  mop_protection #(.TICK_CYCLES(4)) mop_protection_i (
    .clock(clock), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .motorCurrent(motorCurrent), .motorSpeed(motorSpeed),
    .powerStageOverload(powerStageOverload), .inTermPin(inTermPin), .resetPin(resetPin),
    .motorHeatAlarmOut(motorHeatAlarmOut), .motorHeatPrealarmDisplay(motorHeatPrealarmDisplay),
    .outputShutoff(outputShutoff), .faultCode(faultCode), .outTerm(outTerm), .irq(irq));

  mop_relay_model #(.TERM(1)) mop_relay_model_i (
    .clock(clock), .relayHot(relayHot), .resetReq(resetReq),
    .inTermPin(inTermPin), .resetPin(resetPin));

  // verdict and end of run
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // one comparison of a 32-bit result
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] t=%0t got=%08h exp=%08h", $time, got, exp);
    end
  endtask

  // one apb transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge clock);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) begin
      n_fail++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // register read with comparison
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask

  // bounded wait: 0 alarm, 1 shutoff
  task automatic waitFor(input int which);
    int n;
    for (n = 0; n < 20000; n++) begin
      @(posedge clock);
      if (which == 0 && motorHeatAlarmOut === 1'b1) break;
      if (which == 1 && outputShutoff === 1'b1) break;
    end
    if (n >= 20000) begin
      n_fail++;
      finish_test();
    end
  endtask

  // reset switch pressed and released, then trip and heat are gone
  task automatic pressReset();
    resetReq <= 1'b1;
    repeat (10) @(posedge clock);
    resetReq <= 1'b0;
    repeat (10) @(posedge clock);
    chk(32'(outputShutoff), 32'h0);
    chk(32'(faultCode), 32'h0);
    rdchk(`MOP_ADDR_HEAT, 32'h0);
  endtask

  // reset values, clamp and unmapped access
  task automatic t_regs();
    rdchk(`MOP_ADDR_SETTING, 32'h0000000A);
    chk(32'(err), 32'h0);
    apb(1'b1, `MOP_ADDR_SETTING, 32'h000003FF);
    rdchk(`MOP_ADDR_SETTING, 32'h000001F4);
    rdchk(`MOP_ADDR_INTMASK, 32'h0);
    apb(1'b0, 8'h1C, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
  endtask

  // heat rises to alarm, then trips and stays latched
  task automatic t_trip();
    apb(1'b1, `MOP_ADDR_SETTING, 32'h0000000A);
    apb(1'b1, `MOP_ADDR_OUTFUNC, {16'h0000, `MOP_CODE_ALARM_NEG, `MOP_CODE_ALARM_POS});
    apb(1'b1, `MOP_ADDR_INTMASK, 32'h0000000F);
    chk(32'(outTerm), 32'h2);
    motorCurrent <= 10'h1F4;
    waitFor(0);
    chk(32'(motorHeatPrealarmDisplay), 32'h1);
    chk(32'(outputShutoff), 32'h0);
    chk(32'(faultCode), 32'h0);
    repeat (2) @(posedge clock);
    chk(32'(outTerm), 32'h1);
    chk(32'(irq), 32'h1);
    waitFor(1);
    chk(32'(faultCode), 32'(mop_pkg::MOP_MOTOR_OVERLOAD_FAULT));
    rdchk(`MOP_ADDR_HEAT, 32'(`MOP_HEAT_TRIP));
    rdchk(`MOP_ADDR_STATUS, 32'h00000007);
    motorCurrent <= 10'h000;
    repeat (40) @(posedge clock);
    chk(32'(outputShutoff), 32'h1);
    rdchk(`MOP_ADDR_INTSTAT, 32'h3);
    apb(1'b1, `MOP_ADDR_INTSTAT, 32'h3);
    rdchk(`MOP_ADDR_INTSTAT, 32'h0);
    chk(32'(irq), 32'h0);
    pressReset();
  endtask

  // zero setting, power stage trip, relay on the coded terminal only
  task automatic t_zero();
    apb(1'b1, `MOP_ADDR_SETTING, 32'h0);
    motorCurrent <= 10'h1F4;
    repeat (100) @(posedge clock);
    rdchk(`MOP_ADDR_HEAT, 32'h0);
    chk(32'(motorHeatAlarmOut), 32'h0);
    powerStageOverload <= 1'b1;
    repeat (3) @(posedge clock);
    chk(32'(faultCode), 32'(mop_pkg::MOP_POWER_STAGE_OVERLOAD_FAULT));
    powerStageOverload <= 1'b0;
    pressReset();
    relayHot <= 1'b1;
    repeat (20) @(posedge clock);
    chk(32'(outputShutoff), 32'h0);
    apb(1'b1, `MOP_ADDR_INFUNC, {16'h0000, `MOP_CODE_RELAY, 8'h00});
    waitFor(1);
    chk(32'(faultCode), 32'(mop_pkg::MOP_OUTSIDE_RELAY_FAULT));
    relayHot <= 1'b0;
    motorCurrent <= 10'h000;
    pressReset();
  endtask

  // low speed derates the setting; heat decays to zero
  task automatic t_slow();
    apb(1'b1, `MOP_ADDR_SETTING, 32'h00000028);
    motorCurrent <= 10'h023;
    repeat (40) @(posedge clock);
    rdchk(`MOP_ADDR_HEAT, 32'h0);
    motorSpeed <= 13'h0064;
    repeat (40) @(posedge clock);
    apb(1'b0, `MOP_ADDR_HEAT, 32'h0);
    chk(32'(|rd), 32'h1);
    rdchk(`MOP_ADDR_STATUS, 32'h00000020);
    motorCurrent <= 10'h000;
    repeat (200) @(posedge clock);
    rdchk(`MOP_ADDR_HEAT, 32'h0);
  endtask

  // main sequence
  initial begin
    repeat (3) @(posedge clock);
    rst <= 1'b0;
    t_regs();
    t_trip();
    t_zero();
    t_slow();
    finish_test();
  end
endmodule // mop_protection_tb
`default_nettype wire
